//--- rtl/serial_peripheral_port.sv
// Serial peripheral port: master/slave byte exchange with double buffers
`default_nettype none
module serial_peripheral_port (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic                  SCK_IN,
  input  wire logic                  MOSI_IN,
  input  wire logic                  MISO_IN,
  input  wire logic                  SS_N_IN,
  output var  spi_port_pkg::pins_s   PIN_OUT,
  output var  spi_port_pkg::pins_s   PIN_OE_N,
  input  wire logic                  PORT_ENABLE,
  input  wire logic                  MASTER_MODE,
  input  wire logic                  CLK_POL,
  input  wire logic                  CLK_PHA,
  input  wire logic                  LSB_FIRST,
  input  wire logic                  SINGLE_WIRE,
  input  wire logic                  BIDIR_OE,
  input  wire logic                  MODE_FAULT_FLAG_DETECT_EN,
  input  wire logic                  SELECT_OUT_EN,
  input  wire logic                  STOP_IN_WAIT,
  input  wire logic                  WAIT_MODE,
  input  wire logic                  STOP_KEEP,
  input  wire logic                  STOP_LOST,
  input  wire logic [7:0]            BAUD_DIV,
  input  wire logic [7:0]            MATCH_VALUE,
  input  wire logic                  DATA_WR,
  input  wire logic [7:0]            DATA_WDATA,
  input  wire logic                  DATA_RD,
  input  wire logic                  MATCH_CLR,
  input  wire logic                  MODE_FAULT_FLAG_CLR,
  output logic      [7:0]            DATA_RDATA,
  output logic                       TX_EMPTY,
  output logic                       RX_FULL,
  output logic                       MATCH_FLAG,
  output logic                       MODE_FAULT,
  output logic                       BUSY
);
  spi_port_pkg::core_s  m;
  spi_port_pkg::core_s  next_m;
  spi_port_pkg::slave_s s;
  spi_port_pkg::slave_s next_s;
  logic [7:0] s_base;
  logic       s_dout;
  logic       s_out;
  logic       s_clk;
  logic       s_arst_n;
  logic [2:0] s_cnt;
  logic [7:0] s_sh;
  logic [7:0] s_rx;
  logic       s_tog;
  logic       mosi_s1, mosi_s2, miso_s1, miso_s2, ss_s1, ss_s2;
  logic       tog_s1, tog_s2, tog_s3;
  logic       en_m, en_s, pause, half_done, m_in, mode_fault_flag_hit, s_evt;

  // Shift one bit in, honouring bit order
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  // Bit presented next on the data line
  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction : out_bit

  // Mode decode
  assign en_m      = PORT_ENABLE & MASTER_MODE;
  assign en_s      = PORT_ENABLE & ~MASTER_MODE;
  assign pause     = (WAIT_MODE & STOP_IN_WAIT) | STOP_KEEP;
  assign half_done = (m.div == BAUD_DIV);
  assign m_in      = SINGLE_WIRE ? mosi_s2 : miso_s2;
  assign mode_fault_flag_hit  = en_m & MODE_FAULT_FLAG_DETECT_EN & ~SELECT_OUT_EN & ~ss_s2;
  assign s_evt     = tog_s2 ^ tog_s3;

  // Pin synchronisers and slave byte-event crossing
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      ss_s1   <= 1'b1;
      ss_s2   <= 1'b1;
      tog_s1  <= 1'b0;
      tog_s2  <= 1'b0;
      tog_s3  <= 1'b0;
    end
    else
    begin
      mosi_s1 <= MOSI_IN;
      mosi_s2 <= mosi_s1;
      miso_s1 <= MISO_IN;
      miso_s2 <= miso_s1;
      ss_s1   <= SS_N_IN;
      ss_s2   <= ss_s1;
      tog_s1  <= s.tog;
      tog_s2  <= tog_s1;
      tog_s3  <= tog_s2;
    end
  end

  // Master engine, buffers and status next state
  always_comb
  begin
    next_m = m;
    if (DATA_RD)
      next_m.rx_full = 1'b0;
    if (MATCH_CLR)
      next_m.match = 1'b0;
    if (MODE_FAULT_FLAG_CLR)
      next_m.mode_fault_flag = 1'b0;
    case (m.st)
      spi_port_pkg::ST_IDLE:
      begin
        next_m.sck = CLK_POL;
        next_m.div = '0;
        if (en_m && !pause && !m.tx_empty && !mode_fault_flag_hit)
        begin
          next_m.sh       = m.txb;
          next_m.tx_empty = 1'b1;
          next_m.dout     = out_bit(m.txb, LSB_FIRST);
          next_m.cnt      = '0;
          next_m.st       = spi_port_pkg::ST_LEAD;
        end
      end
      spi_port_pkg::ST_LEAD:
      begin
        if (!pause)
        begin
          if (half_done)
          begin
            next_m.div = '0;
            next_m.sck = ~CLK_POL;
            if (CLK_PHA)
              next_m.dout = out_bit(m.sh, LSB_FIRST);
            else
            begin
              next_m.sh  = shift_in(m.sh, m_in, LSB_FIRST);
              next_m.cnt = m.cnt + 4'h1;
            end
            next_m.st = spi_port_pkg::ST_TRAIL;
          end
          else
            next_m.div = m.div + 8'h01;
        end
      end
      spi_port_pkg::ST_TRAIL:
      begin
        if (!pause)
        begin
          if (half_done)
          begin
            next_m.div = '0;
            next_m.sck = CLK_POL;
            if (CLK_PHA)
            begin
              next_m.sh  = shift_in(m.sh, m_in, LSB_FIRST);
              next_m.cnt = m.cnt + 4'h1;
            end
            else
              next_m.dout = out_bit(m.sh, LSB_FIRST);
            if (next_m.cnt == spi_port_pkg::BYTE_DONE)
            begin
              next_m.rxb     = next_m.sh;
              next_m.rx_full = 1'b1;
              if (next_m.sh == MATCH_VALUE)
                next_m.match = 1'b1;
              next_m.st = spi_port_pkg::ST_IDLE;
            end
            else
              next_m.st = spi_port_pkg::ST_LEAD;
          end
          else
            next_m.div = m.div + 8'h01;
        end
      end
      default:
        next_m.st = spi_port_pkg::ST_IDLE;
    endcase
    // Slave byte finished in the link domain
    if (s_evt && en_s)
    begin
      next_m.rxb      = s.rx;
      next_m.rx_full  = 1'b1;
      next_m.s_loaded = 1'b0;
      if (s.rx == MATCH_VALUE)
        next_m.match = 1'b1;
    end
    // Hand the queued byte to the slave shifter
    if (en_s && !next_m.s_loaded && !m.tx_empty)
    begin
      next_m.txs      = m.txb;
      next_m.tx_empty = 1'b1;
      next_m.s_loaded = 1'b1;
    end
    if (DATA_WR)
    begin
      next_m.txb      = DATA_WDATA;
      next_m.tx_empty = 1'b0;
    end
    if (mode_fault_flag_hit)
    begin
      next_m.mode_fault_flag = 1'b1;
      next_m.st   = spi_port_pkg::ST_IDLE;
      next_m.sck  = CLK_POL;
    end
    if (!PORT_ENABLE)
    begin
      next_m.st       = spi_port_pkg::ST_IDLE;
      next_m.sck      = CLK_POL;
      next_m.tx_empty = 1'b1;
      next_m.rx_full  = 1'b0;
      next_m.match    = 1'b0;
      next_m.mode_fault_flag     = 1'b0;
      next_m.s_loaded = 1'b0;
    end
    if (STOP_LOST)
      next_m = spi_port_pkg::CORE_RESET;
  end

  // Master engine registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      m <= spi_port_pkg::CORE_RESET;
    else
      m <= next_m;
  end

  // Link domain: sample edge follows polarity and phase
  assign s_clk    = SCK_IN ^ CLK_POL ^ CLK_PHA;
  assign s_arst_n = RST_N & ~SS_N_IN & en_s;
  assign s_base   = (s.cnt == 3'h0) ? m.txs : s.sh;
  // Slave state gathered from its two register groups
  assign s        = '{cnt: s_cnt, sh: s_sh, rx: s_rx, tog: s_tog};

  // Slave shifter next state
  always_comb
  begin
    next_s     = s;
    next_s.sh  = shift_in(s_base, SINGLE_WIRE ? MISO_IN : MOSI_IN, LSB_FIRST);
    next_s.cnt = s.cnt + 3'h1;
    if (s.cnt == spi_port_pkg::S_LAST)
    begin
      next_s.rx  = next_s.sh;
      next_s.tog = ~s.tog;
    end
  end

  // Frame part, cleared when select rises
  always_ff @(posedge s_clk or negedge s_arst_n)
  begin
    if (!s_arst_n)
    begin
      s_cnt <= spi_port_pkg::SLAVE_RESET.cnt;
      s_sh  <= spi_port_pkg::SLAVE_RESET.sh;
    end
    else
    begin
      s_cnt <= next_s.cnt;
      s_sh  <= next_s.sh;
    end
  end

  // Result part, survives between frames
  always_ff @(posedge s_clk or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_rx  <= spi_port_pkg::SLAVE_RESET.rx;
      s_tog <= spi_port_pkg::SLAVE_RESET.tog;
    end
    else
    begin
      s_rx  <= next_s.rx;
      s_tog <= next_s.tog;
    end
  end

  // Slave output changes on the opposite edge
  always_ff @(negedge s_clk or negedge s_arst_n)
  begin
    if (!s_arst_n)
      s_dout <= 1'b0;
    else
      s_dout <= out_bit(s.sh, LSB_FIRST);
  end
  assign s_out = (s.cnt == 3'h0) ? out_bit(m.txs, LSB_FIRST) : s_dout;

  // Pin routing and enables
  always_comb
  begin
    PIN_OUT.sck    = m.sck;
    PIN_OUT.mosi   = m.dout;
    PIN_OUT.miso   = s_out;
    PIN_OUT.ss_n   = (m.st == spi_port_pkg::ST_IDLE);
    PIN_OE_N.sck   = ~en_m;
    PIN_OE_N.mosi  = ~(en_m & (~SINGLE_WIRE | BIDIR_OE));
    PIN_OE_N.miso  = ~(en_s & ~ss_s2 & (~SINGLE_WIRE | BIDIR_OE));
    PIN_OE_N.ss_n  = ~(en_m & MODE_FAULT_FLAG_DETECT_EN & SELECT_OUT_EN);
  end

  // Status outputs
  assign DATA_RDATA = m.rxb;
  assign TX_EMPTY   = m.tx_empty;
  assign RX_FULL    = m.rx_full;
  assign MATCH_FLAG = m.match;
  assign MODE_FAULT = m.mode_fault_flag;
  assign BUSY       = (m.st != spi_port_pkg::ST_IDLE);

  // Checks on the bus-clock domain
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_disabled_release: assert property (!PORT_ENABLE |-> PIN_OE_N == 4'hf)
    else $error("pins driven while disabled");
  a_disable_clears: assert property (!PORT_ENABLE && !DATA_WR |=> !RX_FULL && TX_EMPTY && !MODE_FAULT)
    else $error("status not cleared on disable");
  a_tx_moves_start: assert property (m.st == spi_port_pkg::ST_IDLE && next_m.st == spi_port_pkg::ST_LEAD
    && !DATA_WR |=> TX_EMPTY && m.sh == $past(m.txb))
    else $error("tx buffer not moved at start");
  a_rx_after_eight: assert property (m.st != spi_port_pkg::ST_IDLE && next_m.st == spi_port_pkg::ST_IDLE
    && PORT_ENABLE && !mode_fault_flag_hit && !STOP_LOST |=> RX_FULL && m.cnt == spi_port_pkg::BYTE_DONE)
    else $error("byte not delivered after eight bits");
  a_pause_hold: assert property (en_m && pause && BUSY && !mode_fault_flag_hit && !STOP_LOST |=> $stable(m.sh) && $stable(m.sck))
    else $error("master moved while paused");
  a_match_flag: assert property ($rose(RX_FULL) && DATA_RDATA == MATCH_VALUE && !$past(MATCH_CLR) |-> MATCH_FLAG)
    else $error("match not flagged");
  a_mode_fault_flag_idle: assert property (mode_fault_flag_hit && !STOP_LOST |=> MODE_FAULT && !BUSY && PIN_OUT.sck == $past(CLK_POL))
    else $error("mode fault not handled");
  a_single_wire_route: assert property (en_m && SINGLE_WIRE |-> PIN_OE_N.miso && PIN_OE_N.mosi == !BIDIR_OE)
    else $error("single wire master routing wrong");
  a_lost_reset: assert property (STOP_LOST |=> !BUSY && TX_EMPTY && !RX_FULL && DATA_RDATA == 8'h00)
    else $error("registers not reset after wake");
  a_idle_clock: assert property (PORT_ENABLE && !BUSY && $stable(CLK_POL) |=> PIN_OUT.sck == $past(CLK_POL))
    else $error("idle clock level wrong");

  c_master_byte: cover property (BUSY ##[1:300] $rose(RX_FULL));
  c_slave_byte:  cover property (en_s && s_evt);
  c_back_back:   cover property ($rose(BUSY) ##[1:300] !BUSY && next_m.st == spi_port_pkg::ST_LEAD);
  c_mode_fault:  cover property ($rose(MODE_FAULT));
endmodule : serial_peripheral_port
`default_nettype wire

//--- rtl/spi_port_pkg.sv
// Shared types and constants for the serial peripheral port
`default_nettype none
package spi_port_pkg;
  localparam int          DW        = 8;
  localparam logic [3:0]  BYTE_DONE = 4'h8;
  localparam logic [2:0]  S_LAST    = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b100
  } mstate_e;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_s;

  typedef struct packed {
    mstate_e       st;
    logic [7:0]    div;
    logic [3:0]    cnt;
    logic [DW-1:0] sh;
    logic          dout;
    logic          sck;
    logic [DW-1:0] txb;
    logic [DW-1:0] rxb;
    logic [DW-1:0] txs;
    logic          tx_empty;
    logic          rx_full;
    logic          match;
    logic          mode_fault_flag;
    logic          s_loaded;
  } core_s;

  typedef struct packed {
    logic [2:0]    cnt;
    logic [DW-1:0] sh;
    logic [DW-1:0] rx;
    logic          tog;
  } slave_s;

  localparam core_s CORE_RESET = '{st: ST_IDLE, tx_empty: 1'b1, default: '0};
  localparam slave_s SLAVE_RESET = '0;
endpackage : spi_port_pkg
`default_nettype wire

//--- sim/serial_peripheral_port_tb.sv
// Self-checking bench for the serial peripheral port
`default_nettype none
module serial_peripheral_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 64; // 16 half bits of BAUD_DIV+1 = 4 cycles
  logic CLK = 1'b0, RST_N = 1'b0, MASTER_MODE = 1'b1, MODE_FAULT_FLAG_DETECT_EN = 1'b1, SELECT_OUT_EN = 1'b1;
  logic PORT_ENABLE = 1'b1, CLK_POL = 1'b0, CLK_PHA = 1'b0, LSB_FIRST = 1'b0, SINGLE_WIRE = 1'b0;
  logic BIDIR_OE = 1'b0, STOP_IN_WAIT = 1'b0, WAIT_MODE = 1'b0, STOP_KEEP = 1'b0, STOP_LOST = 1'b0;
  logic DATA_WR = 1'b0, DATA_RD = 1'b0, MATCH_CLR = 1'b0, MODE_FAULT_FLAG_CLR = 1'b0;
  logic [7:0] BAUD_DIV = 8'h03, MATCH_VALUE = 8'h3c, DATA_WDATA = 8'h00, reply = 8'h00;
  logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1;
  spi_port_pkg::pins_s PIN_OUT, PIN_OE_N;
  logic [7:0] DATA_RDATA, cap;
  logic TX_EMPTY, RX_FULL, MATCH_FLAG, MODE_FAULT, BUSY, part_miso;
  wire logic sck_pin, mosi_pin, miso_pin, ss_pin;
  int comparisons = 0;
  int miscompares = 0;
  // Pin levels from every party's enable
  assign sck_pin = PIN_OE_N.sck ? tb_sck : PIN_OUT.sck;
  assign mosi_pin = PIN_OE_N.mosi ? tb_mosi : PIN_OUT.mosi;
  assign miso_pin = PIN_OE_N.miso ? part_miso : PIN_OUT.miso;
  assign ss_pin = PIN_OE_N.ss_n ? tb_ss_n : PIN_OUT.ss_n;
  always #50 CLK = ~CLK;
  serial_peripheral_port u_dut (.CLK, .RST_N, .SCK_IN(sck_pin), .MOSI_IN(mosi_pin), .MISO_IN(miso_pin),
    .SS_N_IN(ss_pin), .PIN_OUT, .PIN_OE_N, .PORT_ENABLE, .MASTER_MODE, .CLK_POL, .CLK_PHA, .LSB_FIRST,
    .SINGLE_WIRE, .BIDIR_OE, .MODE_FAULT_FLAG_DETECT_EN, .SELECT_OUT_EN, .STOP_IN_WAIT, .WAIT_MODE, .STOP_KEEP,
    .STOP_LOST, .BAUD_DIV, .MATCH_VALUE, .DATA_WR, .DATA_WDATA, .DATA_RD, .MATCH_CLR, .MODE_FAULT_FLAG_CLR,
    .DATA_RDATA, .TX_EMPTY, .RX_FULL, .MATCH_FLAG, .MODE_FAULT, .BUSY);
  spi_slave_model u_far (.sck(sck_pin), .mosi(mosi_pin), .ss_n(ss_pin), .reply(reply), .miso(part_miso),
    .captured(cap));
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // One master byte, optional pause mid-byte
  task automatic master_xfer(input logic lsb, input logic [1:0] pause, input logic [7:0] tx, rep, erx,
                             ecap, input logic emat);
    int n;
    logic [1:0] s;
    MASTER_MODE = 1'b1;
    LSB_FIRST = lsb;
    reply = rep;
    DATA_WDATA = tx;
    DATA_WR = 1'b1;
    step(1);
    DATA_WR = 1'b0;
    check("tx_empty", 8'h00, TX_EMPTY);
    n = 0;
    while (BUSY !== 1'b1 && n < 8)
    begin
      step(1);
      n++;
    end
    check("oe sck", 8'h00, PIN_OE_N.sck);
    check("oe miso", 8'h01, PIN_OE_N.miso);
    check("select out", 8'h00, PIN_OUT.ss_n);
    n = 0;
    while (RX_FULL !== 1'b1 && n < 300)
    begin
      if (pause != 2'b00 && n == 8)
      begin
        {WAIT_MODE, STOP_IN_WAIT, STOP_KEEP} = (pause == 2'b01) ? 3'b001 : 3'b110;
        step(2);
        s = {PIN_OUT.sck, PIN_OUT.mosi};
        step(20);
        check("paused pins", s, {PIN_OUT.sck, PIN_OUT.mosi});
        check("paused busy", 8'h01, BUSY);
        {WAIT_MODE, STOP_IN_WAIT, STOP_KEEP} = 3'b000;
      end
      step(1);
      n++;
    end
    check("latency ok", 8'h01, n >= BASE - 1 && n <= BASE + 2);
    check("rx data", erx, DATA_RDATA);
    check("far captured", ecap, cap);
    check("match", emat, MATCH_FLAG);
    DATA_RD = 1'b1;
    MATCH_CLR = 1'b1;
    step(1);
    {DATA_RD, MATCH_CLR} = 2'b00;
    check("rx_full clear", 8'h00, RX_FULL);
    check("match clear", 8'h00, MATCH_FLAG);
    $display("Done master byte %h", tx);
  endtask : master_xfer
  // Bench acts as master with a 15 ns link clock, faster than the bus clock, in the given clock mode
  task automatic slave_xfer(input logic pol, pha, input logic [7:0] tx, rx);
    logic [7:0] got;
    MASTER_MODE = 1'b0;
    {CLK_POL, CLK_PHA} = {pol, pha};
    tb_sck = pol;
    DATA_WDATA = tx;
    DATA_WR = 1'b1;
    step(1);
    DATA_WR = 1'b0;
    tb_ss_n = 1'b0;
    step(4);
    for (int i = 7; i >= 0; i--)
    begin
      if (pha)
        tb_sck = ~pol;
      tb_mosi = rx[i];
      #7.5;
      got = {got[6:0], miso_pin};
      tb_sck = ~tb_sck;
      #7.5;
      if (!pha)
        tb_sck = pol;
    end
    step(6);
    tb_ss_n = 1'b1;
    tb_mosi = ~tb_mosi;
    check("slave out", tx, got);
    check("slave rx", rx, DATA_RDATA);
    check("slave full", 8'h01, RX_FULL);
    {CLK_POL, CLK_PHA} = 2'b00;
    tb_sck = 1'b0;
    $display("Done slave byte %h", rx);
  endtask : slave_xfer
  // Disable releases pins and clears status
  task automatic disable_test();
    PORT_ENABLE = 1'b0;
    step(1);
    check("released", 8'h0f, PIN_OE_N);
    check("full gone", 8'h00, RX_FULL);
    check("tx empty", 8'h01, TX_EMPTY);
    PORT_ENABLE = 1'b1;
    $display("Done disable");
  endtask : disable_test
  // Wake from state-losing stop resets content
  task automatic stop_test();
    STOP_LOST = 1'b1;
    step(1);
    STOP_LOST = 1'b0;
    step(1);
    check("wake full", 8'h00, RX_FULL);
    check("wake data", 8'h00, DATA_RDATA);
    $display("Done stop wake");
  endtask : stop_test
  // Single-wire pin directions
  task automatic pins_test();
    {MASTER_MODE, SINGLE_WIRE, BIDIR_OE} = 3'b111;
    step(1);
    check("mw oe", 8'h01, {PIN_OE_N.mosi, PIN_OE_N.miso});
    BIDIR_OE = 1'b0;
    step(1);
    check("mw in", 8'h03, {PIN_OE_N.mosi, PIN_OE_N.miso});
    {MASTER_MODE, BIDIR_OE} = 2'b01;
    tb_ss_n = 1'b0;
    step(4);
    check("sw oe", 8'h02, {PIN_OE_N.mosi, PIN_OE_N.miso});
    {tb_ss_n, SINGLE_WIRE} = 2'b10;
    $display("Done pins");
  endtask : pins_test
  // Select pulled low as mode-fault input stops the master
  task automatic mode_fault_flag_test();
    {MASTER_MODE, SELECT_OUT_EN} = 2'b10;
    DATA_WDATA = 8'h99;
    DATA_WR = 1'b1;
    step(1);
    DATA_WR = 1'b0;
    step(2);
    check("mode_fault_flag busy", 8'h01, BUSY);
    tb_ss_n = 1'b0;
    step(4);
    check("mode_fault_flag flag", 8'h01, MODE_FAULT);
    check("mode_fault_flag idle", 8'h00, BUSY);
    tb_ss_n = 1'b1;
    step(3);
    MODE_FAULT_FLAG_CLR = 1'b1;
    step(1);
    MODE_FAULT_FLAG_CLR = 1'b0;
    check("mode_fault_flag clear", 8'h00, MODE_FAULT);
    SELECT_OUT_EN = 1'b1;
    $display("Done mode fault");
  endtask : mode_fault_flag_test
  // Main sequence
  initial
  begin
    step(3);
    RST_N = 1'b1;
    check("reset empty", 8'h01, TX_EMPTY);
    check("reset data", 8'h00, {RX_FULL, MATCH_FLAG, MODE_FAULT, BUSY});
    master_xfer(1'b0, 2'b00, 8'ha5, 8'h3c, 8'h3c, 8'ha5, 1'b1);
    master_xfer(1'b1, 2'b01, 8'h1e, 8'h0f, 8'hf0, 8'h78, 1'b0);
    master_xfer(1'b0, 2'b10, 8'hc0, 8'h01, 8'h01, 8'hc0, 1'b0);
    slave_xfer(1'b0, 1'b0, 8'h5a, 8'hc3);
    disable_test();
    slave_xfer(1'b1, 1'b1, 8'ha6, 8'h81);
    stop_test();
    pins_test();
    mode_fault_flag_test();
    finish_test();
  end
  // Watchdog, far beyond the expected run
  initial
  begin
    #3000000;
    miscompares++;
    finish_test();
  end
endmodule : serial_peripheral_port_tb
`default_nettype wire

//--- sim/spi_slave_model.sv
// External serial slave model, clock mode 0, first bit most significant
`default_nettype none
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic      [7:0] captured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  // Idle values
  initial
  begin
    miso = 1'b0;
    captured = 8'h00;
  end
  // Load reply when selected, first bit out at once
  always @(negedge ss_n)
  begin
    sh = reply;
    miso = sh[7];
  end
  // Sample on the leading clock edge of the master
  always @(posedge sck)
    if (!ss_n) captured = {captured[6:0], mosi};
  // Next bit out on the trailing edge
  always @(negedge sck)
  begin
    if (!ss_n)
    begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
  // Deselected: line no longer holds the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule : spi_slave_model
`default_nettype wire
